// *** ddr2_sio_pkg.sv ***
// Constants, field layouts and carrier types of the burst-of-two separate-I/O SRAM port.
// Assumes a 200 MHz system clock and a link clock that runs the synchronous pins.
package ddr2_sio_pkg;

    // ==========================================================
    // Widths
    localparam int DATA_W  = 18;
    localparam int LANE_W  = 9;
    localparam int LANES   = 2;
    localparam int ADDR_W  = 20;
    localparam int ZQ_W    = 4;
    localparam int CNT_W   = 11;

    // ==========================================================
    // Timing
    localparam int SYS_PERIOD_PS = 5000;
    localparam int STOP_TIME_NS  = 30;
    localparam int STOP_CYC      = (STOP_TIME_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    localparam int LOCK_CYC      = 1024;
    localparam int IMP_CYC       = 1024;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] w0;
        logic [DATA_W-1:0] w1;
    } rd_stage_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  bws_n;
    } wr_word_t;

    localparam rd_stage_t RD_IDLE  = '0;
    localparam wr_word_t  WR_EMPTY = '0;

endpackage : ddr2_sio_pkg

// *** ddr2_sio_port.sv ***
// Separate-I/O DDR burst-of-two SRAM: link-side pipeline, posted write, DLL and impedance timers.
// Assumes address, control and write data arrive synchronous to the link clock pins.
`timescale 1ns/1ps

module ddr2_sio_port #(
    parameter int LOCK_CYC = ddr2_sio_pkg::LOCK_CYC,
    parameter int IMP_CYC  = ddr2_sio_pkg::IMP_CYC,
    parameter int STOP_CYC = ddr2_sio_pkg::STOP_CYC
) (
    input  wire logic                              SYS_CLK_IN,
    input  wire logic                              RST_IN,
    input  wire logic                              CE_IN,
    input  wire logic                              LINK_CLK_IN,
    input  wire logic                              C_IN,
    input  wire logic                              C_N_IN,
    input  wire logic                              LOAD_STROBE_N_IN,
    input  wire logic                              READ_WRITE_SEL_IN,
    input  wire logic [ddr2_sio_pkg::ADDR_W-1:0]   ADDR_IN,
    input  wire logic [ddr2_sio_pkg::DATA_W-1:0]   WRITE_DATA_IN,
    input  wire logic [ddr2_sio_pkg::LANES-1:0]    BYTE_WRITE_SEL_N_IN,
    input  wire logic                              DLL_DISABLE_N_IN,
    input  wire logic [ddr2_sio_pkg::ZQ_W-1:0]     IMPEDANCE_REF_PIN_IN,
    output logic      [ddr2_sio_pkg::DATA_W-1:0]   READ_DATA_OUT,
    output logic                                   READ_DATA_OE_OUT,
    output logic                                   RETURNED_OUTPUT_STROBE_OUT,
    output logic                                   RETURNED_OUTPUT_STROBE_N_OUT,
    output logic                                   DLL_LOCKED_OUT,
    output logic      [ddr2_sio_pkg::ZQ_W-1:0]     DRIVE_IMPEDANCE_OUT,
    output logic                                   IMPEDANCE_UPDATE_OUT
);

    localparam int DW = ddr2_sio_pkg::DATA_W;
    localparam int AW = ddr2_sio_pkg::ADDR_W;
    localparam int CW = ddr2_sio_pkg::CNT_W;
    localparam logic [CW-1:0] STOP_LIM = CW'(STOP_CYC);
    localparam logic [CW-1:0] LOCK_LIM = CW'(LOCK_CYC);
    localparam logic [CW-1:0] IMP_LIM  = CW'(IMP_CYC - 1);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    // ==========================================================
    // Functions
    function automatic logic [DW-1:0] merge_lanes(input logic [DW-1:0] old_w,
                                                  input ddr2_sio_pkg::wr_word_t nw);
        logic [DW-1:0] r;
        r = old_w;
        for (int l = 0; l < ddr2_sio_pkg::LANES; l++) begin
            if (!nw.bws_n[l]) begin
                r[l*ddr2_sio_pkg::LANE_W +: ddr2_sio_pkg::LANE_W] =
                    nw.data[l*ddr2_sio_pkg::LANE_W +: ddr2_sio_pkg::LANE_W];
            end
        end
        return r;
    endfunction : merge_lanes

    function automatic logic [DW-1:0] fwd(input logic [DW-1:0] w, input logic [AW-1:0] a,
                                          input logic hv, input logic [AW-1:0] ha,
                                          input ddr2_sio_pkg::wr_word_t h);
        return (hv && a == ha) ? merge_lanes(w, h) : w;
    endfunction : fwd

    // ==========================================================
    // Link domain synchronisers
    logic dll_n_meta_ff, dll_n_sync_ff, single_meta_ff, single_link_ff;
    logic ce_meta_ff, ce_link_ff, k_tog_ff;
    logic single_ff;

    always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            dll_n_meta_ff  <= 1'b0;
            dll_n_sync_ff  <= 1'b0;
            single_meta_ff <= 1'b0;
            single_link_ff <= 1'b0;
            ce_meta_ff     <= 1'b0;
            ce_link_ff     <= 1'b0;
        end else begin
            dll_n_meta_ff  <= DLL_DISABLE_N_IN;
            dll_n_sync_ff  <= dll_n_meta_ff;
            single_meta_ff <= single_ff;
            single_link_ff <= single_meta_ff;
            ce_meta_ff     <= CE_IN;
            ce_link_ff     <= ce_meta_ff;
        end
    end

    // Clock activity marker for the DLL monitor
    always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            k_tog_ff <= 1'b0;
        end else begin
            k_tog_ff <= ~k_tog_ff;
        end
    end

    // ==========================================================
    // Requests and posted write
    logic [2*DW-1:0]          mem [1<<AW];
    logic                     acc_rd, acc_wr, dll_on;
    logic                     wr_pend_ff, w1_due_ff, hold_valid_ff;
    logic [AW-1:0]            wr_addr_ff, hold_addr_ff;
    ddr2_sio_pkg::wr_word_t   hold_w0_ff, hold_w1_ff, in_word;
    logic [2*DW-1:0]          mem_old, commit_word;

    assign dll_on  = dll_n_sync_ff;
    assign acc_rd  = ce_link_ff && !LOAD_STROBE_N_IN && READ_WRITE_SEL_IN;
    assign acc_wr  = ce_link_ff && !LOAD_STROBE_N_IN && !READ_WRITE_SEL_IN;
    assign in_word = '{data: WRITE_DATA_IN, bws_n: BYTE_WRITE_SEL_N_IN};
    assign mem_old = mem[hold_addr_ff];
    assign commit_word = {merge_lanes(mem_old[2*DW-1:DW], hold_w1_ff),
                          merge_lanes(mem_old[DW-1:0], hold_w0_ff)};

    always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wr_pend_ff    <= 1'b0;
            wr_addr_ff    <= '0;
            w1_due_ff     <= 1'b0;
            hold_valid_ff <= 1'b0;
            hold_addr_ff  <= '0;
            hold_w0_ff    <= ddr2_sio_pkg::WR_EMPTY;
        end else if (ce_link_ff) begin
            wr_pend_ff <= acc_wr;
            if (acc_wr) begin
                wr_addr_ff <= ADDR_IN;
            end
            w1_due_ff <= wr_pend_ff;
            if (wr_pend_ff) begin
                hold_valid_ff <= 1'b1;
                hold_addr_ff  <= wr_addr_ff;
                hold_w0_ff    <= in_word;
            end
        end
    end

    // Held write reaches the array when the next write delivers data
    always_ff @(posedge LINK_CLK_IN) begin
        if (ce_link_ff && wr_pend_ff && hold_valid_ff) begin
            mem[hold_addr_ff] <= commit_word;
        end
    end

    always_ff @(negedge LINK_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hold_w1_ff <= ddr2_sio_pkg::WR_EMPTY;
        end else if (ce_link_ff && w1_due_ff) begin
            hold_w1_ff <= in_word;
        end
    end

    // ==========================================================
    // Read pipeline
    ddr2_sio_pkg::rd_stage_t s0_ff, s1_ff;
    logic [2*DW-1:0]         rd_raw;
    logic [DW-1:0]           q_pos_ff, q_neg_ff, s1_w1_now;
    logic                    oe_pos_ff, oe_neg_ff;

    assign rd_raw = mem[ADDR_IN];

    always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s0_ff <= ddr2_sio_pkg::RD_IDLE;
            s1_ff <= ddr2_sio_pkg::RD_IDLE;
        end else if (ce_link_ff) begin
            s0_ff.valid <= acc_rd;
            s0_ff.addr  <= ADDR_IN;
            s0_ff.w0    <= fwd(rd_raw[DW-1:0], ADDR_IN, hold_valid_ff, hold_addr_ff,
                               hold_w0_ff);
            s0_ff.w1    <= fwd(rd_raw[2*DW-1:DW], ADDR_IN, hold_valid_ff, hold_addr_ff,
                               hold_w1_ff);
            s1_ff.valid <= s0_ff.valid;
            s1_ff.addr  <= s0_ff.addr;
            s1_ff.w0    <= fwd(s0_ff.w0, s0_ff.addr, hold_valid_ff, hold_addr_ff, hold_w0_ff);
            s1_ff.w1    <= fwd(s0_ff.w1, s0_ff.addr, hold_valid_ff, hold_addr_ff, hold_w1_ff);
        end
    end

    always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            q_pos_ff  <= '0;
            oe_pos_ff <= 1'b0;
        end else if (ce_link_ff) begin
            if (dll_on) begin
                q_pos_ff  <= s1_ff.w1;
                oe_pos_ff <= s1_ff.valid;
            end else begin
                q_pos_ff  <= fwd(s0_ff.w0, s0_ff.addr, hold_valid_ff, hold_addr_ff,
                                 hold_w0_ff);
                oe_pos_ff <= s0_ff.valid;
            end
        end
    end

    always_ff @(negedge LINK_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            q_neg_ff  <= '0;
            oe_neg_ff <= 1'b0;
        end else if (ce_link_ff) begin
            q_neg_ff  <= dll_on ? s1_ff.w0 : s1_ff.w1;
            oe_neg_ff <= s1_ff.valid;
        end
    end

    // Double rate output and echo clocks
    assign READ_DATA_OUT    = LINK_CLK_IN ? q_pos_ff : q_neg_ff;
    assign READ_DATA_OE_OUT = LINK_CLK_IN ? oe_pos_ff : oe_neg_ff;
    assign RETURNED_OUTPUT_STROBE_OUT   = single_link_ff ? LINK_CLK_IN : C_IN;
    assign RETURNED_OUTPUT_STROBE_N_OUT = single_link_ff ? ~LINK_CLK_IN : C_N_IN;

    // ==========================================================
    // System domain: strap, DLL and impedance
    logic [1:0]      c_meta_ff, c_sync_ff, strap_cnt_ff;
    logic            tog_meta_ff, tog_sync_ff, tog_prev_ff, k_tick, strap_done_ff;
    logic            dn_meta_ff, dn_sync_ff, dll_stopped, locked_ff, imp_upd_ff;
    logic [CW-1:0]   stop_cnt_ff, lock_cnt_ff, imp_cnt_ff;
    logic [ddr2_sio_pkg::ZQ_W-1:0] zq_meta_ff, zq_sync_ff, imp_code_ff;

    assign k_tick      = tog_sync_ff ^ tog_prev_ff;
    assign dll_stopped = stop_cnt_ff >= STOP_LIM;

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            c_meta_ff   <= 2'h0;
            c_sync_ff   <= 2'h0;
            tog_meta_ff <= 1'b0;
            tog_sync_ff <= 1'b0;
            tog_prev_ff <= 1'b0;
            dn_meta_ff  <= 1'b0;
            dn_sync_ff  <= 1'b0;
            zq_meta_ff  <= '0;
            zq_sync_ff  <= '0;
        end else if (CE_IN) begin
            c_meta_ff   <= {C_IN, C_N_IN};
            c_sync_ff   <= c_meta_ff;
            tog_meta_ff <= k_tog_ff;
            tog_sync_ff <= tog_meta_ff;
            tog_prev_ff <= tog_sync_ff;
            dn_meta_ff  <= DLL_DISABLE_N_IN;
            dn_sync_ff  <= dn_meta_ff;
            zq_meta_ff  <= IMPEDANCE_REF_PIN_IN;
            zq_sync_ff  <= zq_meta_ff;
        end
    end

    // Strap taken once after release, kept until the next reset
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            strap_cnt_ff  <= 2'h0;
            strap_done_ff <= 1'b0;
            single_ff     <= 1'b0;
        end else if (CE_IN && !strap_done_ff) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == ddr2_sio_pkg::STRAP_WAIT) begin
                strap_done_ff <= 1'b1;
                single_ff     <= &c_sync_ff;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            stop_cnt_ff <= '0;
            lock_cnt_ff <= '0;
            locked_ff   <= 1'b0;
        end else if (CE_IN) begin
            if (k_tick) begin
                stop_cnt_ff <= '0;
            end else if (!dll_stopped) begin
                stop_cnt_ff <= stop_cnt_ff + CNT_ONE;
            end
            if (dll_stopped || !dn_sync_ff) begin
                lock_cnt_ff <= '0;
                locked_ff   <= 1'b0;
            end else if (k_tick && !locked_ff) begin
                lock_cnt_ff <= lock_cnt_ff + CNT_ONE;
                locked_ff   <= (lock_cnt_ff + CNT_ONE) == LOCK_LIM;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            imp_cnt_ff  <= '0;
            imp_upd_ff  <= 1'b0;
            imp_code_ff <= '0;
        end else if (CE_IN) begin
            imp_upd_ff <= 1'b0;
            if (k_tick) begin
                if (imp_cnt_ff == IMP_LIM) begin
                    imp_cnt_ff  <= '0;
                    imp_upd_ff  <= 1'b1;
                    imp_code_ff <= zq_sync_ff;
                end else begin
                    imp_cnt_ff <= imp_cnt_ff + CNT_ONE;
                end
            end
        end
    end

    assign DLL_LOCKED_OUT       = locked_ff;
    assign DRIVE_IMPEDANCE_OUT  = imp_code_ff;
    assign IMPEDANCE_UPDATE_OUT = imp_upd_ff;

    // ==========================================================
    // Assertions
    logic [DW-1:0] s1_w1_now_unused;
    assign s1_w1_now = s1_ff.w1;
    assign s1_w1_now_unused = s1_w1_now;

    a_read_capture: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        acc_rd |=> s0_ff.valid && s0_ff.addr == $past(ADDR_IN))
        else $error("read request not captured");
    a_dll_on_first: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        ce_link_ff && s1_ff.valid && dll_on && $stable(dll_on) |-> oe_neg_ff && q_neg_ff == s1_ff.w0)
        else $error("first word missing on falling half");
    a_dll_off_first: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        acc_rd && !dll_on ##1 ce_link_ff && !dll_on |=> oe_pos_ff)
        else $error("dll off first word late");
    a_second_word: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        ce_link_ff && dll_on && s1_ff.valid |=> q_pos_ff == $past(s1_w1_now) && oe_pos_ff)
        else $error("second word wrong");
    a_back_to_back: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        acc_rd ##1 acc_rd |=> s0_ff.valid && s1_ff.valid)
        else $error("pipelined reads dropped");
    a_out_release: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        ce_link_ff && !s0_ff.valid && !s1_ff.valid |=> !oe_pos_ff)
        else $error("output driven without pending read");
    a_write_capture: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        acc_wr ##1 ce_link_ff |=> hold_valid_ff && hold_addr_ff == $past(ADDR_IN, 2))
        else $error("write address not held");
    a_lane_keep: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        hold_w0_ff.bws_n[0] |-> commit_word[ddr2_sio_pkg::LANE_W-1:0] ==
                                mem_old[ddr2_sio_pkg::LANE_W-1:0])
        else $error("deselected lane overwritten");
    a_posted_hold: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        hold_valid_ff && !wr_pend_ff |=> hold_valid_ff && $stable(hold_addr_ff))
        else $error("posted write lost");
    a_stop_reset: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        CE_IN && dll_stopped |=> !locked_ff && lock_cnt_ff == '0)
        else $error("dll not reset on stopped clock");
    a_lock_count: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        $rose(locked_ff) |-> lock_cnt_ff == LOCK_LIM)
        else $error("dll locked at wrong count");
    a_imp_period: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        imp_upd_ff |-> imp_cnt_ff == '0 && $past(imp_cnt_ff) == IMP_LIM)
        else $error("impedance update off period");

    c_read: cover property (@(posedge LINK_CLK_IN) disable iff (RST_IN) acc_rd ##2 oe_pos_ff);
    c_write: cover property (@(posedge LINK_CLK_IN) disable iff (RST_IN) acc_wr ##1 acc_wr);
    c_rd_after_wr: cover property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
        acc_wr ##1 acc_rd ##1 acc_wr);
    c_lock: cover property (@(posedge SYS_CLK_IN) disable iff (RST_IN) $rose(locked_ff));

endmodule : ddr2_sio_port

// *** ctrl_model.sv ***
// Memory controller model: load strobe, select, address and write data.
// Assumes the bench queues requests; one is issued per link clock rise.
`timescale 1ns/1ps
module ctrl_model (
    input  wire logic                        link_clk_in,
    output logic                             strobe_n_out,
    output logic                             sel_out,
    output logic [ddr2_sio_pkg::ADDR_W-1:0]  addr_out,
    output ddr2_sio_pkg::wr_word_t           word_out
);
    // ==========================================================
    // Request queue
    typedef struct packed {
        logic                            rd;
        logic [ddr2_sio_pkg::ADDR_W-1:0] a;
        ddr2_sio_pkg::wr_word_t          w0;
        ddr2_sio_pkg::wr_word_t          w1;
    } req_t;
    req_t q[$];
    req_t r;
    req_t p1;
    req_t p2;
    req_t cur;
    logic p1_v = 1'h0;
    logic p2_v = 1'h0;
    logic do1  = 1'h0;
    initial begin
        strobe_n_out = 1'h1;
        sel_out      = 1'h0;
        addr_out     = '0;
        word_out     = '0;
    end
    // ==========================================================
    // Address phase on the rise, own strobe for this bank
    always @(posedge link_clk_in) begin
        p2_v <= p1_v;
        p2   <= p1;
        p1_v <= 1'h0;
        if (do1) begin
            word_out <= cur.w1;
        end
        if (q.size() > 0) begin
            r = q.pop_front();
            strobe_n_out <= 1'h0;
            sel_out      <= r.rd;
            addr_out     <= r.a;
            p1           <= r;
            p1_v         <= ~r.rd;
        end else begin
            strobe_n_out <= 1'h1;
            sel_out      <= ~sel_out;
            addr_out     <= ~addr_out;
        end
    end
    // ==========================================================
    // First word on the fall; released lines show the inverse
    always @(negedge link_clk_in) begin
        do1 <= p2_v;
        if (p2_v) begin
            word_out <= p2.w0;
            cur      <= p2;
        end else if (!do1) begin
            word_out <= ~word_out;
        end
    end
endmodule : ctrl_model

// *** ddr2_sio_port_tb.sv ***
// Self-checking bench of the burst-of-two SRAM port with a controller model.
// Assumes single clock strap (output clock pins high) and short lock counts.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module ddr2_sio_port_tb;
    localparam int LK = 8;
    logic                   sys_clk  = 1'h0;
    logic                   rst      = 1'h1;
    logic                   link_clk = 1'h0;
    logic                   kstop    = 1'h0;
    logic                   dll_n    = 1'h1;
    logic [3:0]             zq       = 4'ha;
    logic [17:0]            rdata;
    logic                   oe;
    logic                   cq;
    logic                   cq_n;
    logic                   locked;
    logic [3:0]             drv_imp;
    logic                   imp_upd;
    logic                   strobe_n;
    logic                   sel;
    logic [19:0]            addr;
    ddr2_sio_pkg::wr_word_t word;
    int                     error_cnt = 0;
    int                     n_tests   = 0;
    int                     kcnt      = 0;
    int                     cyc       = 0;
    bit                     dll_on    = 1'b1;
    logic [35:0]            mem[int];
    logic [17:0]            ed[$];
    logic [17:0]            cd[$];
    int                     ec[$];
    int                     cc[$];
    event                   pre_edge;

    ddr2_sio_port #(.LOCK_CYC(LK), .IMP_CYC(LK), .STOP_CYC(40)) ddr2_sio_port_inst (
        .SYS_CLK_IN(sys_clk), .RST_IN(rst), .CE_IN(1'h1), .LINK_CLK_IN(link_clk),
        .C_IN(1'h1), .C_N_IN(1'h1), .LOAD_STROBE_N_IN(strobe_n), .READ_WRITE_SEL_IN(sel),
        .ADDR_IN(addr), .WRITE_DATA_IN(word.data), .BYTE_WRITE_SEL_N_IN(word.bws_n),
        .DLL_DISABLE_N_IN(dll_n), .IMPEDANCE_REF_PIN_IN(zq), .READ_DATA_OUT(rdata),
        .READ_DATA_OE_OUT(oe), .RETURNED_OUTPUT_STROBE_OUT(cq),
        .RETURNED_OUTPUT_STROBE_N_OUT(cq_n), .DLL_LOCKED_OUT(locked),
        .DRIVE_IMPEDANCE_OUT(drv_imp), .IMPEDANCE_UPDATE_OUT(imp_upd));
    ctrl_model ctrl_model_inst (.link_clk_in(link_clk), .strobe_n_out(strobe_n),
        .sel_out(sel), .addr_out(addr), .word_out(word));

    // ==========================================================
    // Clocks, capture of driven words, timeout
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #12;
        forever begin
            #39;
            if (!kstop) begin
                ->pre_edge;
            end
            #1 if (!kstop) link_clk = ~link_clk;
        end
    end
    always @(posedge link_clk) kcnt++;
    always @(pre_edge) begin
        if (oe === 1'h1) begin
            cd.push_back(rdata);
            cc.push_back(kcnt);
        end
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ==========================================================
    // Shared tasks
    function automatic logic [17:0] mg(input logic [17:0] o, n, input logic [1:0] b);
        mg = {b[1] ? o[17:9] : n[17:9], b[0] ? o[8:0] : n[8:0]};
    endfunction : mg
    task automatic op(input logic rd, input logic [19:0] a, input logic [17:0] w0, w1,
                      input logic [1:0] b0, b1);
        int t;
        t = kcnt + 2 + ctrl_model_inst.q.size();
        ctrl_model_inst.q.push_back({rd, a, w0, b0, w1, b1});
        if (rd) begin
            ed.push_back(mem[a][17:0]);
            ec.push_back(t + 1);
            ed.push_back(mem[a][35:18]);
            ec.push_back(dll_on ? t + 2 : t + 1);
        end else begin
            mem[a] = {mg(mem[a][35:18], w1, b1), mg(mem[a][17:0], w0, b0)};
        end
    endtask : op
    task automatic drain();
        logic [17:0] g;
        int          c;
        repeat (12) @(posedge link_clk);
        `CHK(cd.size(), ed.size())
        while (ed.size() > 0 && cd.size() > 0) begin
            g = cd.pop_front();
            c = cc.pop_front();
            `CHK(g, ed.pop_front())
            `CHK(c, ec.pop_front())
        end
        ed.delete();
        cd.delete();
        ec.delete();
        cc.delete();
    endtask : drain
    task automatic finish_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        `CHK(oe, 1'h0)
        `CHK(locked, 1'h0)
    endtask : t_reset
    task automatic t_lock();
        int n;
        n = 0;
        while (locked !== 1'h1 && n < 600) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(locked, 1'h1)
        `CHK(n > (LK - 2) * 16, 1'h1)
    endtask : t_lock
    task automatic t_echo();
        repeat (20) begin
            @(negedge sys_clk);
            `CHK(cq, link_clk)
            `CHK(cq_n, ~link_clk)
        end
    endtask : t_echo
    task automatic t_rw();
        @(negedge link_clk);
        op(1'h0, 20'h10, 18'h1a1a1, 18'h25b5b, 2'h0, 2'h0);
        op(1'h0, 20'h20, 18'h0c3c3, 18'h3d2d2, 2'h0, 2'h0);
        op(1'h0, 20'h30, 18'h2e4e4, 18'h11717, 2'h0, 2'h0);
        op(1'h1, 20'h10, 18'h0, 18'h0, 2'h0, 2'h0);
        op(1'h1, 20'h20, 18'h0, 18'h0, 2'h0, 2'h0);
        op(1'h1, 20'h30, 18'h0, 18'h0, 2'h0, 2'h0);
        drain();
    endtask : t_rw
    task automatic t_bytes();
        @(negedge link_clk);
        op(1'h0, 20'h10, 18'h3ffff, 18'h00000, 2'h2, 2'h1);
        op(1'h0, 20'h40, 18'h15555, 18'h2aaaa, 2'h0, 2'h0);
        op(1'h1, 20'h10, 18'h0, 18'h0, 2'h0, 2'h0);
        op(1'h1, 20'h40, 18'h0, 18'h0, 2'h0, 2'h0);
        drain();
    endtask : t_bytes
    task automatic t_imp();
        int n;
        n = 0;
        while (imp_upd !== 1'h1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(drv_imp, 4'ha)
        @(negedge sys_clk);
        n = 1;
        while (imp_upd !== 1'h1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(n >= LK * 16 - 8 && n <= LK * 16 + 8, 1'h1)
    endtask : t_imp
    task automatic t_dlloff();
        @(negedge sys_clk);
        dll_n = 1'h0;
        repeat (4) @(posedge link_clk);
        dll_on = 1'b0;
        @(negedge link_clk);
        op(1'h1, 20'h20, 18'h0, 18'h0, 2'h0, 2'h0);
        op(1'h1, 20'h40, 18'h0, 18'h0, 2'h0, 2'h0);
        drain();
        @(negedge sys_clk);
        dll_n = 1'h1;
        dll_on = 1'b1;
        repeat (4) @(posedge link_clk);
    endtask : t_dlloff
    task automatic t_stop();
        @(negedge sys_clk);
        kstop = 1'h1;
        #400;
        `CHK(locked, 1'h0)
        kstop = 1'h0;
        t_lock();
    endtask : t_stop

    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 1'h0;
        t_reset();
        t_lock();
        t_echo();
        t_rw();
        t_bytes();
        t_imp();
        t_dlloff();
        t_stop();
        finish_test();
    end
endmodule : ddr2_sio_port_tb
